// ---- verilog/wdt_pkg.sv ----
// Purpose: shared constants for the windowed watchdog
// Assumes: 8-bit register port, one system clock
// Notes: period codes above the last valid code give no timeout
package wdt_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CODE_W = 4;
    localparam int CNT_W = 14;
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_WINDOW = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_UNLOCK = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 3'h4;
    // field positions, shared by both control registers
    localparam int BIT_CHANGE = 0;
    localparam int BIT_ENABLE = 1;
    localparam int FLD_PER_LO = 2;
    localparam int FLD_PER_HI = 5;
    // status bits
    localparam int BIT_ST_RUN = 0;
    localparam int BIT_ST_OPEN = 1;
    localparam int BIT_ST_UNLOCKED = 2;
    localparam int BIT_ST_LOCKFUSE = 3;
    // unlock key, value arbitrary
    localparam logic [DATA_W-1:0] UNLOCK_KEY = 8'hd8;
    // unlock interval in system clock cycles
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    // period decode: code 0 gives 8 ticks, doubling up to the last code
    localparam logic [CNT_W-1:0] BASE_TICKS = 14'h0008;
    localparam logic [CODE_W-1:0] LAST_CODE = 4'ha;
    // values after reset
    localparam logic [CODE_W-1:0] RST_CODE = 4'h0;
    localparam logic RST_BIT = 1'b0;
    localparam logic [CNT_W-1:0] RST_CNT = 14'h0000;
    localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
endpackage : wdt_pkg

// ---- verilog/wdt_period_decode.sv ----
// Purpose: turns a period code into a tick count
// Assumes: code width 4, count wide enough for the longest period
// Notes: reserved codes give valid low and a zero count
`timescale 1ns/1ps
module wdt_period_decode #(
    parameter int CODE_W = 4,
    parameter int CNT_W = 14
) (
    input wire logic [CODE_W-1:0] code,
    output logic [CNT_W-1:0] ticks,
    output logic valid
);
    import wdt_pkg::*;

    if (CNT_W < 14 || CODE_W != 4) begin : g_check
        $error("wdt_period_decode: widths cannot hold the longest period");
    end

    assign valid = (code <= LAST_CODE);
    assign ticks = valid ? CNT_W'(BASE_TICKS << code) : CNT_W'(0);
endmodule : wdt_period_decode

// ---- verilog/windowed_watchdog_timer.sv ----
// Purpose: watchdog with normal and window mode, fuse loaded settings
// Assumes: tick is a one-cycle pulse at 1 kHz, synchronous to mclk
// Notes: sysReset is a one-cycle pulse; counting restarts after it
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - missed restart before timeout resets system
// - normal mode restart anytime, restarts full period
// - period code n gives 8 shl n ticks
// - reserved period codes never time out
// - restart in closed window resets immediately
// - open follows closed; open restart reopens closed
// - period field sets open window length
// - counter advances only on 1kHz tick
// - reset works without main clocks running; here sysReset and the counter are registered on mclk
// - control write needs change-enable bit set
// - enable bit starts, clearing stops watchdog
// - writes need timed unlock first
// - lock fuse freezes whole control register
// - lock fuse freezes closed period, not mode
// - after system reset watchdog keeps running configured
// - fuses load period and enable at power-on
// - top two bits read zero, write zero
// - control layout: period 5:2, enable 1, change 0
// - closed period uses same code encoding
// - window write needs window change-enable bit
// - window layout: period 5:2, mode 1, change 0
module windowed_watchdog_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic restartReq,
    input wire logic lockFuse,
    input wire logic [wdt_pkg::CODE_W-1:0] periodFuseField,
    input wire logic enableFuse,
    input wire logic [wdt_pkg::CODE_W-1:0] windowPeriodFuseField,
    input wire logic windowFuse,
    input wire logic [wdt_pkg::ADDR_W-1:0] addr,
    input wire logic [wdt_pkg::DATA_W-1:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [wdt_pkg::DATA_W-1:0] rdData,
    output logic sysReset
);
    import wdt_pkg::*;

    typedef enum logic [2:0] {
        ST_STOPPED = 3'b001,
        ST_CLOSED = 3'b010,
        ST_OPEN = 3'b100
    } phase_e;

    phase_e stateQ;
    phase_e stateD;
    logic [CNT_W-1:0] cntQ;
    logic [CNT_W-1:0] cntD;
    logic sysResetD;
    logic sysResetQ;
    logic loadedQ;
    logic [CODE_W-1:0] perQ;
    logic enQ;
    logic cenQ;
    logic [CODE_W-1:0] wperQ;
    logic wenQ;
    logic wcenQ;
    logic [2:0] unlockQ;
    logic [DATA_W-1:0] rdDataQ;

    // address decode
    wire hitControl = (addr == OFF_CONTROL);
    wire hitWindow = (addr == OFF_WINDOW);
    wire hitUnlock = (addr == OFF_UNLOCK);
    wire hitStatus = (addr == OFF_STATUS);
    wire unlocked = (unlockQ != 3'h0);
    wire protWrite = wrEn && unlocked && (hitControl || hitWindow);
    wire ctrlTake = protWrite && hitControl && wrData[BIT_CHANGE] && !lockFuse;
    wire winTake = protWrite && hitWindow && wrData[BIT_CHANGE];
    wire wperTake = winTake && !lockFuse;

    // period decode for open and closed windows
    logic [CNT_W-1:0] openTicks;
    logic openValid;
    logic [CNT_W-1:0] closedTicks;
    logic closedValid;

    wdt_period_decode #(.CODE_W(CODE_W), .CNT_W(CNT_W)) u_open_decode (
        .code(perQ),
        .ticks(openTicks),
        .valid(openValid)
    );

    wdt_period_decode #(.CODE_W(CODE_W), .CNT_W(CNT_W)) u_closed_decode (
        .code(wperQ),
        .ticks(closedTicks),
        .valid(closedValid)
    );

    // phase ends, counted in ticks only
    wire [CNT_W-1:0] cntInc = cntQ + CNT_W'(1);
    wire openDone = tick && openValid && (cntInc >= openTicks);
    wire closedDone = tick && (!closedValid || cntInc >= closedTicks);
    wire startPhaseClosed = wenQ;
    phase_e startPhase;
    assign startPhase = startPhaseClosed ? ST_CLOSED : ST_OPEN;

    // phase machine; restart wins over a tick in the same cycle
    always_comb begin
        stateD = stateQ;
        cntD = cntQ;
        sysResetD = 1'b0;
        case (stateQ)
            ST_STOPPED: begin
                if (enQ) begin
                    stateD = startPhase;
                    cntD = RST_CNT;
                end
            end
            ST_CLOSED: begin
                if (!enQ) begin
                    stateD = ST_STOPPED;
                    cntD = RST_CNT;
                end else if (restartReq) begin
                    sysResetD = 1'b1;
                    stateD = startPhase;
                    cntD = RST_CNT;
                end else if (closedDone) begin
                    stateD = ST_OPEN;
                    cntD = RST_CNT;
                end else if (tick) begin
                    cntD = cntInc;
                end
            end
            ST_OPEN: begin
                if (!enQ) begin
                    stateD = ST_STOPPED;
                    cntD = RST_CNT;
                end else if (restartReq) begin
                    stateD = startPhase;
                    cntD = RST_CNT;
                end else if (openDone) begin
                    sysResetD = 1'b1;
                    stateD = startPhase;
                    cntD = RST_CNT;
                end else if (tick && openValid) begin
                    cntD = cntInc;
                end
            end
            default: begin
                stateD = ST_STOPPED;
                cntD = RST_CNT;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= ST_STOPPED;
            cntQ <= RST_CNT;
            sysResetQ <= RST_BIT;
        end else begin
            stateQ <= stateD;
            cntQ <= cntD;
            sysResetQ <= sysResetD;
        end
    end

    // timed unlock: key write opens a short write interval
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unlockQ <= 3'h0;
        end else if (wrEn && hitUnlock && wrData == UNLOCK_KEY) begin
            unlockQ <= UNLOCK_CYCLES;
        end else if (protWrite) begin
            unlockQ <= 3'h0;
        end else if (unlocked) begin
            unlockQ <= unlockQ - 3'h1;
        end
    end

    // one-shot load flag for the fuse values
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            loadedQ <= RST_BIT;
        end else begin
            loadedQ <= 1'b1;
        end
    end

    // control register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            perQ <= RST_CODE;
            enQ <= RST_BIT;
            cenQ <= RST_BIT;
        end else if (!loadedQ) begin
            perQ <= periodFuseField;
            enQ <= enableFuse;
        end else if (ctrlTake) begin
            perQ <= wrData[FLD_PER_HI:FLD_PER_LO];
            enQ <= wrData[BIT_ENABLE];
            cenQ <= wrData[BIT_CHANGE];
        end
    end

    // window register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wperQ <= RST_CODE;
            wenQ <= RST_BIT;
            wcenQ <= RST_BIT;
        end else if (!loadedQ) begin
            wperQ <= windowPeriodFuseField;
            wenQ <= windowFuse;
        end else begin
            if (wperTake) begin
                wperQ <= wrData[FLD_PER_HI:FLD_PER_LO];
            end
            if (winTake) begin
                wenQ <= wrData[BIT_ENABLE];
                wcenQ <= wrData[BIT_CHANGE];
            end
        end
    end

    // read mux; top two bits always zero
    wire [DATA_W-1:0] ctrlView = {2'b00, perQ, enQ, cenQ};
    wire [DATA_W-1:0] winView = {2'b00, wperQ, wenQ, wcenQ};
    wire [DATA_W-1:0] statusView = {4'h0, lockFuse, unlocked,
        (stateQ == ST_OPEN), (stateQ != ST_STOPPED)};
    wire [DATA_W-1:0] rdMux = hitControl ? ctrlView :
        hitWindow ? winView :
        hitStatus ? statusView : RST_DATA;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdDataQ <= RST_DATA;
        end else begin
            rdDataQ <= rdEn ? rdMux : RST_DATA;
        end
    end

    assign rdData = rdDataQ;
    assign sysReset = sysResetQ;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_open_timeout_fires: assert property (
        stateQ == ST_OPEN && enQ && !restartReq && openDone |=> sysReset
    ) else $error("open period expired without system reset");

    a_restart_clears_count: assert property (
        stateQ == ST_OPEN && enQ && restartReq |=> cntQ == RST_CNT && !sysReset
    ) else $error("open restart did not start a fresh period");

    a_reserved_no_timeout: assert property (
        stateQ == ST_OPEN && enQ && !openValid && !restartReq |=> !sysReset && $stable(cntQ)
    ) else $error("reserved period code produced a timeout");

    a_closed_restart_fault: assert property (
        stateQ == ST_CLOSED && enQ && restartReq |=> sysReset ##1 !sysReset
    ) else $error("restart in closed window not punished at once");

    a_closed_then_open: assert property (
        stateQ == ST_CLOSED && enQ && !restartReq && closedDone
        |=> stateQ == ST_OPEN && cntQ == RST_CNT
    ) else $error("open window did not follow closed window");

    a_count_only_tick: assert property (
        stateQ != ST_STOPPED && enQ && !tick && !restartReq && !ctrlTake
        |=> $stable(cntQ)
    ) else $error("counter moved without a tick");

    a_ctrl_needs_cen: assert property (
        loadedQ && !(protWrite && hitControl && wrData[BIT_CHANGE])
        |=> $stable(perQ) && $stable(enQ)
    ) else $error("control changed without unlock and change enable");

    a_lock_freezes_ctrl: assert property (
        loadedQ && lockFuse |=> $stable(perQ) && $stable(enQ) && $stable(cenQ)
    ) else $error("locked control register changed");

    a_lock_keeps_wper: assert property (
        loadedQ && lockFuse |=> $stable(wperQ)
    ) else $error("locked closed period changed");

    a_fuse_load: assert property (
        !loadedQ |=> perQ == $past(periodFuseField) && enQ == $past(enableFuse) && !cenQ
    ) else $error("fuse values not loaded at power-on");

    a_top_bits_zero: assert property (
        rdData[DATA_W-1:DATA_W-2] == 2'b00
    ) else $error("reserved read bits not zero");

    a_stop_on_disable: assert property (
        loadedQ && !enQ |=> stateQ == ST_STOPPED ##1 !sysReset
    ) else $error("watchdog kept running while disabled");

    a_window_write_gated: assert property (
        loadedQ && !winTake |=> $stable(wenQ) && $stable(wcenQ)
    ) else $error("window register changed without change enable");

    a_key_opens_unlock: assert property (
        wrEn && hitUnlock && wrData == UNLOCK_KEY |=> unlockQ == UNLOCK_CYCLES
    ) else $error("unlock key did not open the write interval");

    a_unlock_expires: assert property (
        unlockQ == 3'h1 && !(wrEn && hitUnlock) |=> !unlocked
    ) else $error("write interval outlived its length");

    a_locked_write_dropped: assert property (
        loadedQ && wrEn && !unlocked
        |=> $stable(perQ) && $stable(enQ) && $stable(wperQ) && $stable(wenQ)
    ) else $error("register changed by a write outside the interval");

    a_start_phase: assert property (
        stateQ == ST_STOPPED && enQ
        |=> cntQ == RST_CNT && stateQ == ($past(wenQ) ? ST_CLOSED : ST_OPEN)
    ) else $error("enable did not start the right phase");

    a_resume_after_reset: assert property (
        sysReset |-> stateQ != ST_STOPPED && cntQ == RST_CNT
    ) else $error("watchdog stopped after its own reset");

    a_lock_mode_writable: assert property (
        loadedQ && lockFuse && winTake |=> wenQ == $past(wrData[BIT_ENABLE])
    ) else $error("window mode not writable under lock");

    a_ctrl_write_lands: assert property (
        loadedQ && ctrlTake
        |=> perQ == $past(wrData[FLD_PER_HI:FLD_PER_LO]) && enQ == $past(wrData[BIT_ENABLE])
    ) else $error("accepted control write not stored");

    a_read_idle_zero: assert property (
        !rdEn |=> rdData == RST_DATA
    ) else $error("read data shown without a read strobe");

    c_normal_timeout: cover property (stateQ == ST_OPEN && !wenQ ##1 sysReset);
    c_window_open_restart: cover property (stateQ == ST_OPEN && wenQ && restartReq);
    c_closed_violation: cover property (stateQ == ST_CLOSED && restartReq);
    c_unlocked_write: cover property (ctrlTake);
    c_locked_window_write: cover property (winTake && lockFuse);
endmodule : windowed_watchdog_timer

// ---- verif/cpu_model.sv ----
// Purpose: processor core model issuing register accesses and restarts
// Assumes: strobes taken on rising mclk, read data one cycle later
// Notes: every task is entered just after a rising edge
`timescale 1ns/1ps
module cpu_model (
    input wire logic mclk,
    output logic [wdt_pkg::ADDR_W-1:0] addr,
    output logic [wdt_pkg::DATA_W-1:0] wrData,
    output logic wrEn,
    output logic rdEn,
    input wire logic [wdt_pkg::DATA_W-1:0] rdData,
    output logic restartReq
);
    import wdt_pkg::*;
    initial begin
        {addr, wrData, wrEn, rdEn, restartReq} = '0;
    end
    task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge mclk);
    endtask : put
    // released lines show the inverse of the last value
    task automatic idle(input int n);
        wrEn <= 1'b0;
        addr <= ~addr;
        wrData <= ~wrData;
        repeat (n) @(posedge mclk);
    endtask : idle
    // key, then the protected write gap+1 edges later
    task automatic prot(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input int gap);
        put(OFF_UNLOCK, UNLOCK_KEY);
        if (gap > 0) idle(gap);
        put(a, d);
        idle(1);
    endtask : prot
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge mclk);
        rdEn <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        d = rdData;
    endtask : rd
    task automatic restart();
        restartReq <= 1'b1;
        @(posedge mclk);
        restartReq <= 1'b0;
    endtask : restart
endmodule : cpu_model

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the windowed watchdog
// Assumes: tick sped up to one pulse every 4 mclk cycles
// Notes: expectations are in ticks, so the speed-up changes none
`timescale 1ns/1ps
module testbench;
    import wdt_pkg::*;
    logic mclk, tick = 1'b0, tickRun = 1'b0, rst_n = 1'b0, lockFuse = 1'b0, windowFuse = 1'b0;
    logic enableFuse = 1'b0, wrEn, rdEn, restartReq, sysReset;
    logic [1:0] div = 2'h0;
    logic [CODE_W-1:0] periodFuseField = 4'h0, windowPeriodFuseField = 4'h0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData, rdData;
    int errCount = 0, samplesChecked = 0, cycles = 0;
    windowed_watchdog_timer windowed_watchdog_timer_i (.mclk, .rst_n, .tick, .restartReq,
        .lockFuse, .periodFuseField, .enableFuse, .windowPeriodFuseField, .windowFuse,
        .addr, .wrData, .wrEn, .rdEn, .rdData, .sysReset);
    cpu_model cpu_model_i (.mclk, .addr, .wrData, .wrEn, .rdEn, .rdData, .restartReq);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        div <= div + 2'h1;
        tick <= tickRun && div == 2'h3;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errCount = errCount + 1;
            finalReport();
        end
    end
    task automatic finalReport();
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finalReport
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic readChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        cpu_model_i.rd(a, d);
        check("register", {8'h00, d}, {8'h00, exp});
    endtask : readChk
    // ffff means no reset within lim ticks
    task automatic measure(input int lim, input logic [15:0] exp);
        logic [15:0] n;
        n = 16'h0000;
        repeat (lim * 4 + 8) begin
            @(posedge mclk);
            if (sysReset === 1'b1) begin
                check("ticks to reset", n, exp);
                return;
            end
            if (tick === 1'b1) n++;
        end
        check("ticks to reset", 16'hffff, exp);
    endtask : measure
    task automatic waitTicks(input int k);
        repeat (k) begin
            @(posedge mclk);
            while (tick !== 1'b1) @(posedge mclk);
        end
    endtask : waitTicks
    task automatic cfg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        tickRun <= 1'b0;
        repeat (2) @(posedge mclk);
        cpu_model_i.prot(a, d, 0);
        tickRun <= 1'b1;
    endtask : cfg
    task automatic doReset(input logic [10:0] f);
        {lockFuse, periodFuseField, enableFuse, windowPeriodFuseField, windowFuse} <= f;
        tickRun <= 1'b0;
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : doReset
    task automatic tFuses();
        doReset({1'b0, 4'h1, 1'b0, 4'h2, 1'b1});
        readChk(OFF_CONTROL, 8'h04);
        readChk(OFF_WINDOW, 8'h0a);
        readChk(3'h2, 8'h00);
        cpu_model_i.prot(OFF_WINDOW, 8'h09, 0);
        readChk(OFF_WINDOW, 8'h09);
    endtask : tFuses
    task automatic tPeriods();
        logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'h0};
        foreach (codes[i]) begin
            cfg(OFF_CONTROL, {2'b00, codes[i], 2'b11});
            measure(8 << codes[i], 16'(8 << codes[i]));
        end
        measure(8, 16'h0008);
        cfg(OFF_CONTROL, 8'h2f);
        measure(40, 16'hffff);
        cfg(OFF_CONTROL, 8'h01);
        measure(40, 16'hffff);
    endtask : tPeriods
    task automatic tRestart();
        cfg(OFF_CONTROL, 8'h03);
        waitTicks(5);
        cpu_model_i.restart();
        measure(8, 16'h0008);
        waitTicks(7);
        cpu_model_i.restart();
        measure(8, 16'h0008);
    endtask : tRestart
    task automatic tWindow();
        cfg(OFF_CONTROL, 8'h01);
        cpu_model_i.prot(OFF_WINDOW, 8'h07, 0);
        cpu_model_i.prot(OFF_WINDOW, 8'h00, 0);
        readChk(OFF_WINDOW, 8'h07);
        cfg(OFF_CONTROL, 8'h03);
        measure(24, 16'h0018);
        waitTicks(3);
        cpu_model_i.restart();
        @(posedge mclk);
        check("early restart", {15'h0000, sysReset}, 16'h0001);
        waitTicks(18);
        cpu_model_i.restart();
        measure(24, 16'h0018);
    endtask : tWindow
    task automatic tProtect();
        cfg(OFF_CONTROL, 8'h01);
        cpu_model_i.put(OFF_CONTROL, 8'h2f);
        cpu_model_i.idle(1);
        readChk(OFF_CONTROL, 8'h01);
        cpu_model_i.put(OFF_UNLOCK, UNLOCK_KEY);
        cpu_model_i.idle(1);
        readChk(OFF_STATUS, 8'h04);
        cpu_model_i.prot(OFF_CONTROL, 8'h2e, 0);
        readChk(OFF_CONTROL, 8'h01);
        cpu_model_i.prot(OFF_CONTROL, 8'h2f, 4);
        readChk(OFF_CONTROL, 8'h01);
        cpu_model_i.prot(OFF_CONTROL, 8'hc5, 3);
        readChk(OFF_CONTROL, 8'h05);
    endtask : tProtect
    task automatic tLock();
        doReset({1'b1, 4'h0, 1'b1, 4'h0, 1'b0});
        readChk(OFF_CONTROL, 8'h02);
        cpu_model_i.prot(OFF_CONTROL, 8'h01, 0);
        readChk(OFF_CONTROL, 8'h02);
        cpu_model_i.prot(OFF_WINDOW, 8'h2f, 0);
        readChk(OFF_WINDOW, 8'h03);
        readChk(OFF_STATUS, 8'h0b);
        tickRun <= 1'b1;
        measure(8, 16'h0008);
    endtask : tLock
    initial begin
        tFuses();
        tPeriods();
        tRestart();
        tWindow();
        tProtect();
        tLock();
        finalReport();
    end
endmodule : testbench
